// >>> hw/pos_defs.svh
`ifndef POS_DEFS_SVH
`define POS_DEFS_SVH

// register byte offsets
`define POS_OFS_SEG 12'h000
`define POS_OFS_GATE 12'h004
`define POS_OFS_STAT 12'h008
`define POS_OFS_MODE 12'h00C
`define POS_OFS_DA1 12'h010
`define POS_OFS_DB1 12'h014
`define POS_OFS_DC1 12'h018
`define POS_OFS_DA2 12'h01C
`define POS_OFS_DB2 12'h020
`define POS_OFS_DC2 12'h024

// widths and reset values
`define POS_SEG_W 9
`define POS_GATE_W 10
`define POS_SEG_RST 9'h000
`define POS_GATE_RST 10'h000

// segment fields
`define POS_SEG_XA 8
`define POS_SEG_XB 7
`define POS_SEG_XC 6
`define POS_SEG_DAL 5
`define POS_SEG_DAH 4
`define POS_SEG_DBL 3
`define POS_SEG_DBH 2
`define POS_SEG_DCL 1
`define POS_SEG_DCH 0

// gate fields
`define POS_GATE_LO 9
`define POS_GATE_HI 8
`define POS_GATE_DIV_HI 7
`define POS_GATE_DIV_LO 0

// status fields
`define POS_STAT_POL 2
`define POS_STAT_FON 4
`define POS_STAT_FOFF 8

// mode fields
`define POS_MODE_DBL 0
`endif

// >>> hw/pos_pkg.sv
package pos_pkg;

    // six gate drive signals, asserted level means ON
    typedef struct packed {
        logic ah;
        logic al;
        logic bh;
        logic bl;
        logic ch;
        logic cl;
    } pos_gate_t;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } pos_apb_req_t;

    // three phase flags
    typedef struct packed {
        logic a;
        logic b;
        logic c;
    } pos_phase_t;

endpackage

// >>> hw/pos_output_stage.sv
`timescale 1ns/1ps
`include "pos_defs.svh"
// Functional notes
// R1 - single update: same duty values used in both half periods
// R2 - double update: separate duty values for first and second halves
// R3 - nine-bit read/write output segment control register
// R4 - segment bits 8,7,6 enable crossover for phase A, B, C pairs
// R5 - crossover routes high-side signal to low output and vice versa
// R6 - reset clears all three crossover bits
// R7 - segment bits 5..0 disable AL, AH, BL, BH, CL, CH outputs
// R8 - a disabled output holds OFF regardless of duty value
// R9 - disable masking is applied after crossover routing
// R10 - reset clears all six disable bits
// R11 - segment latched at sync rising edge, also midpoint in double mode
// R12 - ten-bit gate chop register with separate high and low enables
// R13 - gate bit 8 enables chopping of the three high-side outputs
// R14 - gate bit 9 enables chopping of the three low-side outputs
// R15 - carrier period is four times divider plus one clock periods
// R16 - divider accepts every value 0 to 255, each distinct
// R17 - chopping modulates only the ON portion of outputs
// R18 - software sets gate chop before running and leaves it alone
// R19 - reset clears every gate chop bit
// R20 - polarity pin low gives active-low outputs, high active-high
// R21 - unconnected polarity pin defaults to active-high outputs
// R22 - status bit 2 reports sampled polarity pin level
// R23 - full on/off when high-side stays constant between sync pulses
// R24 - carrier is free-running square wave with equal halves
// R25 - polarity inversion applied last, after masking and chopping
module pos_output_stage #(
    parameter int DUTY_W = 16
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire pos_pkg::pos_apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pos_pkg::pos_gate_t tu_raw,
    input wire logic cycle_sync_pulse,
    input wire logic half_cycle_mid,
    input wire logic polarity_select_pin,
    output logic [DUTY_W-1:0] phase_a_duty,
    output logic [DUTY_W-1:0] phase_b_duty,
    output logic [DUTY_W-1:0] phase_c_duty,
    output logic double_update,
    output pos_pkg::pos_gate_t gate_out
);

    ////////////////////////////////////////////////////////////////////////
    // reset release
    logic rst_meta_r;
    logic rst_sync_r;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb decode
    logic [`POS_SEG_W-1:0] seg_r;
    logic [`POS_SEG_W-1:0] seg_act_r;
    logic [`POS_GATE_W-1:0] gate_r;
    logic mode_dbl_r;
    logic pol_r;
    pos_pkg::pos_phase_t full_on_r;
    pos_pkg::pos_phase_t full_off_r;
    logic [DUTY_W-1:0] da1_r;
    logic [DUTY_W-1:0] db1_r;
    logic [DUTY_W-1:0] dc1_r;
    logic [DUTY_W-1:0] da2_r;
    logic [DUTY_W-1:0] db2_r;
    logic [DUTY_W-1:0] dc2_r;
    logic [31:0] rd_nxt;
    logic hit_nxt;
    logic setup;
    logic wr_en;
    logic [31:0] prdata_r;
    logic err_r;

    assign setup = apb_req.psel && !apb_req.penable;
    assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign pready = 1'b1;
    assign prdata = prdata_r;
    assign pslverr = apb_req.psel && apb_req.penable && err_r;

    // status is read only: polarity sample and the full on/off flags
    logic [31:0] stat_word;

    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[`POS_STAT_POL] = pol_r; // [R22]
        stat_word[`POS_STAT_FON +: 3] = full_on_r; // [R23]
        stat_word[`POS_STAT_FOFF +: 3] = full_off_r;
    end

    always_comb begin
        rd_nxt = 32'h0000_0000;
        hit_nxt = 1'b1;
        unique case (apb_req.paddr)
            `POS_OFS_SEG: rd_nxt[`POS_SEG_W-1:0] = seg_r; // [R3]
            `POS_OFS_GATE: rd_nxt[`POS_GATE_W-1:0] = gate_r;
            `POS_OFS_STAT: rd_nxt = stat_word;
            `POS_OFS_MODE: rd_nxt[`POS_MODE_DBL] = mode_dbl_r;
            `POS_OFS_DA1: rd_nxt[DUTY_W-1:0] = da1_r;
            `POS_OFS_DB1: rd_nxt[DUTY_W-1:0] = db1_r;
            `POS_OFS_DC1: rd_nxt[DUTY_W-1:0] = dc1_r;
            `POS_OFS_DA2: rd_nxt[DUTY_W-1:0] = da2_r;
            `POS_OFS_DB2: rd_nxt[DUTY_W-1:0] = db2_r;
            `POS_OFS_DC2: rd_nxt[DUTY_W-1:0] = dc2_r;
            default: hit_nxt = 1'b0;
        endcase
    end

    // read data captured in setup, presented in access
    always_ff @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup) begin
            prdata_r <= apb_req.pwrite ? 32'h0000_0000 : rd_nxt;
        end
    end

    // unmapped offsets and status writes are refused
    always_ff @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            err_r <= 1'b0;
        end else if (setup) begin
            err_r <= !hit_nxt || (apb_req.pwrite &&
                apb_req.paddr == `POS_OFS_STAT);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software registers
    always_ff @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            seg_r <= `POS_SEG_RST; // [R6] [R10]
        end else if (wr_en && apb_req.paddr == `POS_OFS_SEG) begin
            seg_r <= apb_req.pwdata[`POS_SEG_W-1:0]; // [R3]
        end
    end

    // gate settings are expected static while running
    always_ff @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            gate_r <= `POS_GATE_RST; // [R19]
        end else if (wr_en && apb_req.paddr == `POS_OFS_GATE) begin
            gate_r <= apb_req.pwdata[`POS_GATE_W-1:0]; // [R12]
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            mode_dbl_r <= 1'b0;
        end else if (wr_en && apb_req.paddr == `POS_OFS_MODE) begin
            mode_dbl_r <= apb_req.pwdata[`POS_MODE_DBL];
        end
    end

    // first-half duty, used for the whole period in single mode
    always_ff @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            da1_r <= '0;
            db1_r <= '0;
            dc1_r <= '0;
        end else if (wr_en) begin
            unique case (apb_req.paddr)
                `POS_OFS_DA1: da1_r <= apb_req.pwdata[DUTY_W-1:0];
                `POS_OFS_DB1: db1_r <= apb_req.pwdata[DUTY_W-1:0];
                `POS_OFS_DC1: dc1_r <= apb_req.pwdata[DUTY_W-1:0];
                default: ;
            endcase
        end
    end

    // second-half duty, only reaches the timing unit in double mode
    always_ff @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            da2_r <= '0;
            db2_r <= '0;
            dc2_r <= '0;
        end else if (wr_en) begin
            unique case (apb_req.paddr)
                `POS_OFS_DA2: da2_r <= apb_req.pwdata[DUTY_W-1:0];
                `POS_OFS_DB2: db2_r <= apb_req.pwdata[DUTY_W-1:0];
                `POS_OFS_DC2: dc2_r <= apb_req.pwdata[DUTY_W-1:0];
                default: ;
            endcase
        end
    end

    assign double_update = mode_dbl_r;

    ////////////////////////////////////////////////////////////////////////
    // update points
    logic sync_d_r;
    logic sync_rise;
    logic mid_load;

    always_ff @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            sync_d_r <= 1'b0;
        end else begin
            sync_d_r <= cycle_sync_pulse;
        end
    end

    assign sync_rise = cycle_sync_pulse && !sync_d_r;
    assign mid_load = half_cycle_mid && mode_dbl_r;

    // software copy reaches the pins only at update points
    always_ff @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            seg_act_r <= `POS_SEG_RST;
        end else if (sync_rise || mid_load) begin
            seg_act_r <= seg_r; // [R11]
        end
    end

    // duty handed to the timing unit per half period
    always_ff @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            phase_a_duty <= '0;
            phase_b_duty <= '0;
            phase_c_duty <= '0;
        end else if (sync_rise) begin
            phase_a_duty <= da1_r; // [R1]
            phase_b_duty <= db1_r;
            phase_c_duty <= dc1_r;
        end else if (mid_load) begin
            phase_a_duty <= da2_r; // [R2]
            phase_b_duty <= db2_r;
            phase_c_duty <= dc2_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // full on / full off tracking on the high-side signals
    pos_pkg::pos_phase_t seen_on_r;
    pos_pkg::pos_phase_t seen_off_r;
    pos_pkg::pos_phase_t hi_now;

    assign hi_now = '{a: tu_raw.ah, b: tu_raw.bh, c: tu_raw.ch};

    // interval history, restarted with the sample taken at each sync edge
    always_ff @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            seen_on_r <= '0;
            seen_off_r <= '0;
        end else if (sync_rise) begin
            seen_on_r <= hi_now;
            seen_off_r <= ~hi_now;
        end else begin
            seen_on_r <= seen_on_r | hi_now;
            seen_off_r <= seen_off_r | ~hi_now;
        end
    end

    // flags describe the interval that the sync edge closes
    always_ff @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            full_on_r <= '0;
            full_off_r <= '0;
        end else if (sync_rise) begin
            full_on_r <= seen_on_r & ~seen_off_r; // [R23]
            full_off_r <= seen_off_r & ~seen_on_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // chopping carrier: half period is 2*(div+1) clocks
    logic [8:0] chop_cnt_r;
    logic [8:0] chop_half_m1;
    logic carrier_r;
    logic [7:0] chop_divider;
    logic chop_end;

    assign chop_divider = gate_r[`POS_GATE_DIV_HI:`POS_GATE_DIV_LO];
    assign chop_half_m1 = {chop_divider, 1'b1}; // [R15] [R16]
    // compare with >= so a smaller divider written mid-count cannot stall
    assign chop_end = chop_cnt_r >= chop_half_m1;

    always_ff @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            chop_cnt_r <= 9'h000;
        end else if (chop_end) begin
            chop_cnt_r <= 9'h000; // [R24]
        end else begin
            chop_cnt_r <= chop_cnt_r + 9'h001;
        end
    end

    // free running from reset, starts low
    always_ff @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            carrier_r <= 1'b0;
        end else if (chop_end) begin
            carrier_r <= !carrier_r; // [R24]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // polarity pin sample, reset value matches the pull-up
    always_ff @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            pol_r <= 1'b1; // [R21]
        end else begin
            pol_r <= polarity_select_pin; // [R22]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output path: crossover, masking, chopping, polarity
    pos_pkg::pos_gate_t xo;
    pos_pkg::pos_gate_t masked;
    pos_pkg::pos_gate_t chopped;
    logic chop_hi;
    logic chop_lo;

    // crossover swaps a pair before any masking
    always_comb begin
        xo = tu_raw;
        if (seg_act_r[`POS_SEG_XA]) begin
            xo.ah = tu_raw.al; // [R4] [R5]
            xo.al = tu_raw.ah;
        end
        if (seg_act_r[`POS_SEG_XB]) begin
            xo.bh = tu_raw.bl; // [R4] [R5]
            xo.bl = tu_raw.bh;
        end
        if (seg_act_r[`POS_SEG_XC]) begin
            xo.ch = tu_raw.cl; // [R4] [R5]
            xo.cl = tu_raw.ch;
        end
    end

    // disable bits act on the pin position left after crossover
    always_comb begin
        masked.al = xo.al && !seg_act_r[`POS_SEG_DAL]; // [R7] [R8] [R9]
        masked.ah = xo.ah && !seg_act_r[`POS_SEG_DAH];
        masked.bl = xo.bl && !seg_act_r[`POS_SEG_DBL];
        masked.bh = xo.bh && !seg_act_r[`POS_SEG_DBH];
        masked.cl = xo.cl && !seg_act_r[`POS_SEG_DCL];
        masked.ch = xo.ch && !seg_act_r[`POS_SEG_DCH];
    end

    assign chop_hi = !gate_r[`POS_GATE_HI] || carrier_r; // [R13]
    assign chop_lo = !gate_r[`POS_GATE_LO] || carrier_r; // [R14]

    // carrier gates only the ON level, an OFF output stays OFF
    always_comb begin
        chopped.ah = masked.ah && chop_hi; // [R17]
        chopped.bh = masked.bh && chop_hi;
        chopped.ch = masked.ch && chop_hi;
        chopped.al = masked.al && chop_lo;
        chopped.bl = masked.bl && chop_lo;
        chopped.cl = masked.cl && chop_lo;
    end

    // outputs start OFF at the reset polarity (active high)
    always_ff @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            gate_out <= '0;
        end else begin
            gate_out <= pol_r ? chopped : ~chopped; // [R20] [R25]
        end
    end

endmodule

// >>> tb/pos_output_stage_properties.sv
`timescale 1ns/1ps
`include "pos_defs.svh"
module pos_output_stage_properties #(
    parameter int DUTY_W = 16
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire pos_pkg::pos_apb_req_t apb_req,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire pos_pkg::pos_gate_t tu_raw,
    input wire logic cycle_sync_pulse,
    input wire logic half_cycle_mid,
    input wire logic polarity_select_pin,
    input wire logic [DUTY_W-1:0] phase_a_duty,
    input wire logic double_update,
    input wire pos_pkg::pos_gate_t gate_out
);
    logic [2:0] up_r;
    logic live;
    logic acc;
    logic pin;
    assign pin = polarity_select_pin;
    // skip the cycles while the internal reset copy is still held
    assign live = up_r == 3'h7;
    assign acc = apb_req.psel && apb_req.penable && live;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            up_r <= 3'h0;
        end else if (!live) begin
            up_r <= up_r + 3'h1;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////
    AST_READY: assert property (
        acc |-> pready) else $error("no ready in access");
    AST_UNMAPPED: assert property (
        acc && apb_req.paddr > `POS_OFS_DC2
        |-> pslverr && (apb_req.pwrite || prdata == 32'h0))
        else $error("unmapped access accepted");
    AST_STAT_WR: assert property (
        acc && apb_req.pwrite && apb_req.paddr == `POS_OFS_STAT
        |-> pslverr) else $error("status write accepted");
    AST_POL_LOW: assert property (
        (live && !pin && tu_raw == 6'h00) [*3] |=> gate_out == 6'h3F)
        else $error("off level wrong, pin low");
    AST_POL_HIGH: assert property (
        (live && pin && tu_raw == 6'h00) [*3] |=> gate_out == 6'h00)
        else $error("off level wrong, pin high");
    AST_STAT_POL: assert property (
        acc && !apb_req.pwrite && apb_req.paddr == `POS_OFS_STAT
        && $stable(pin) && $past(pin, 2) == pin && $past(pin, 3) == pin
        |-> prdata[2] == pin) else $error("status pol bit wrong");
    AST_DUTY_SINGLE: assert property (
        live && half_cycle_mid && !double_update && !cycle_sync_pulse
        && !$past(cycle_sync_pulse) |=> $stable(phase_a_duty) [*2])
        else $error("duty moved at midpoint");
    AST_DUTY_QUIET: assert property (
        live && $changed(phase_a_duty) |-> $past(cycle_sync_pulse)
        || $past(cycle_sync_pulse, 2) || $past(cycle_sync_pulse, 3)
        || $past(half_cycle_mid) || $past(half_cycle_mid, 2)
        || $past(half_cycle_mid, 3)) else $error("duty moved unasked");
    cover property (acc && pslverr);
    cover property (live && double_update && half_cycle_mid);
    cover property (live && !pin && gate_out != 6'h3F);
endmodule
bind pos_output_stage pos_output_stage_properties #(.DUTY_W(DUTY_W)) i_prop (
    .clk_sys, .rst_b, .apb_req, .prdata, .pready, .pslverr, .tu_raw,
    .cycle_sync_pulse, .half_cycle_mid, .polarity_select_pin,
    .phase_a_duty, .double_update, .gate_out
);

// >>> tb/pos_gate_drive_model.sv
`timescale 1ns/1ps
module pos_gate_drive_model (
    input wire logic strap_en,
    input wire logic strap_lvl,
    input wire pos_pkg::pos_gate_t gate_out,
    output logic pol_pin,
    output pos_pkg::pos_gate_t sw_on
);
    // unstrapped pin floats high through the pull-up
    assign pol_pin = strap_en ? strap_lvl : 1'b1;
    // a switch conducts when its gate level matches the polarity
    assign sw_on = pol_pin ? gate_out : pos_pkg::pos_gate_t'(~gate_out);
endmodule

// >>> tb/test_pos_output_stage.sv
`timescale 1ns/1ps
`include "pos_defs.svh"
module test_pos_output_stage;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    pos_pkg::pos_apb_req_t req = '0;
    pos_pkg::pos_gate_t raw = '0;
    pos_pkg::pos_gate_t gout;
    pos_pkg::pos_gate_t sw_on;
    pos_pkg::pos_gate_t p;
    logic sync = 1'b0;
    logic mid = 1'b0;
    logic strap_en = 1'b0;
    logic strap_lvl = 1'b0;
    logic pol_pin, pready, pslverr, dbl, e;
    logic [31:0] prdata, q;
    logic [15:0] da, db, dc;
    logic [9:0] cfg [4] = '{10'h100, 10'h101, 10'h103, 10'h203};
    int fails = 0;
    int check_count = 0;
    int cyc = 0;
    int nh, th, tl, h;
    always #12.5 clk_sys = ~clk_sys;
    pos_output_stage #(.DUTY_W(16)) i_dut (.clk_sys(clk_sys), .rst_b(rst_b),
        .apb_req(req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tu_raw(raw), .cycle_sync_pulse(sync), .half_cycle_mid(mid),
        .polarity_select_pin(pol_pin), .phase_a_duty(da), .phase_b_duty(db),
        .phase_c_duty(dc), .double_update(dbl), .gate_out(gout));
    pos_gate_drive_model i_drv (.strap_en(strap_en), .strap_lvl(strap_lvl),
        .gate_out(gout), .pol_pin(pol_pin), .sw_on(sw_on));
    ////////////////////////////////////////
    task summarize;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
        check_count++;
        if (g !== x) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", n, x, g);
        end
    endtask
    task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk_sys);
        req.penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        xf(1'b1, a, d);
    endtask
    task rd(input string n, input logic [11:0] a, input logic [31:0] x);
        xf(1'b0, a, 32'h0);
        chk(n, x, q);
    endtask
    task pulse(input logic s);
        @(posedge clk_sys);
        sync <= s;
        mid <= !s;
        @(posedge clk_sys);
        sync <= 1'b0;
        mid <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    task put(input pos_pkg::pos_gate_t v);
        @(posedge clk_sys);
        raw <= v;
        repeat (3) @(posedge clk_sys);
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            summarize();
        end
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd("seg reset", `POS_OFS_SEG, 32'h0);
        rd("gate reset", `POS_OFS_GATE, 32'h0);
        rd("pol status", `POS_OFS_STAT, 32'h4);
        wr(`POS_OFS_SEG, '1);
        rd("seg rw", `POS_OFS_SEG, 32'h1FF);
        wr(`POS_OFS_GATE, '1);
        rd("gate rw", `POS_OFS_GATE, 32'h3FF);
        rd("unmapped", 12'h040, 32'h0);
        chk("unmapped err", 32'h1, e);
        wr(`POS_OFS_STAT, 32'h0);
        chk("status err", 32'h1, e);
        wr(`POS_OFS_GATE, 32'h0);
        $display("registers done");
        for (int i = 0; i < 3; i++) begin
            wr(`POS_OFS_SEG, 32'h100 >> i);
            pulse(1'b1);
            put(6'h20 >> (2 * i));
            chk("cross high", 32'h10 >> (2 * i), gout);
            put(6'h10 >> (2 * i));
            chk("cross low", 32'h20 >> (2 * i), gout);
        end
        for (int k = 0; k < 6; k++) begin
            wr(`POS_OFS_SEG, 32'h0);
            pulse(1'b1);
            put(6'h3F);
            wr(`POS_OFS_SEG, 32'h1 << k);
            chk("before sync", 32'h3F, gout);
            pulse(1'b1);
            chk("disable", 32'h3F ^ (32'h1 << (k ^ 1)), gout);
        end
        wr(`POS_OFS_SEG, 32'h120);
        pulse(1'b1);
        put(6'h20);
        chk("mask after cross", 32'h0, gout);
        wr(`POS_OFS_MODE, 32'h1);
        wr(`POS_OFS_SEG, 32'h0);
        pulse(1'b0);
        chk("mid reload", 32'h20, gout);
        $display("segment done");
        wr(`POS_OFS_DA1, 32'h1234);
        wr(`POS_OFS_DA2, 32'h5678);
        wr(`POS_OFS_DB1, 32'h2345);
        wr(`POS_OFS_DC1, 32'h3456);
        wr(`POS_OFS_DB2, 32'h6789);
        wr(`POS_OFS_DC2, 32'h789A);
        wr(`POS_OFS_MODE, 32'h0);
        pulse(1'b1);
        chk("single first", 32'h1234, da);
        chk("single first b", 32'h2345, db);
        chk("single first c", 32'h3456, dc);
        pulse(1'b0);
        chk("single mid", 32'h1234, da);
        chk("single mid b", 32'h2345, db);
        chk("single mid c", 32'h3456, dc);
        wr(`POS_OFS_MODE, 32'h1);
        pulse(1'b1);
        chk("double first", 32'h1234, da);
        chk("double mode", 32'h1, dbl);
        pulse(1'b0);
        chk("double second", 32'h5678, da);
        chk("double second b", 32'h6789, db);
        chk("double second c", 32'h789A, dc);
        wr(`POS_OFS_MODE, 32'h0);
        $display("duty done");
        @(posedge clk_sys);
        strap_en <= 1'b1;
        put(6'h00);
        chk("off low", 32'h3F, gout);
        put(6'h20);
        chk("on low", 32'h1F, gout);
        chk("switch on", 32'h20, sw_on);
        rd("pol low status", `POS_OFS_STAT, 32'h340);
        chk("pol status low", 32'h0, q & 32'h4);
        wr(`POS_OFS_SEG, 32'h10);
        pulse(1'b1);
        chk("disabled low", 32'h3F, gout);
        wr(`POS_OFS_SEG, 32'h0);
        pulse(1'b1);
        @(posedge clk_sys);
        strap_en <= 1'b0;
        put(6'h30);
        $display("polarity done");
        for (int j = 0; j < 4; j++) begin
            wr(`POS_OFS_GATE, 32'(cfg[j]));
            repeat (20) @(posedge clk_sys);
            h = 2 * (cfg[j][7:0] + 1);
            nh = 0;
            th = 0;
            tl = 0;
            p = gout;
            repeat (48) begin
                @(posedge clk_sys);
                nh += gout.ah;
                th += gout.ah != p.ah;
                tl += gout.al != p.al;
                p = gout;
            end
            chk("high toggles", cfg[j][8] ? 48 / h : 0, th);
            chk("low toggles", cfg[j][9] ? 48 / h : 0, tl);
            chk("high on time", cfg[j][8] ? 24 : 48, nh);
        end
        wr(`POS_OFS_GATE, 32'h0);
        $display("chopping done");
        summarize();
    end
endmodule
